// ### aci_pkg.sv
// Purpose: shared constants and types of the two-wire converter command interface
// Assumes: eight-bit converter, one command byte, one result byte
// Notes:   bit counts number the clock pulses of a byte from 1 (first data bit) to 9 (ack)
package aci_pkg;

    // fixed upper five bits of the bus address (10010)
    localparam logic [4:0] ACI_ADDR_UPPER  = 5'h12;
    // upper five bits of the high-speed master code (00001xxx)
    localparam logic [4:0] ACI_MCODE_UPPER = 5'h01;

    // pulse numbers inside one nine-pulse byte
    localparam logic [3:0] ACI_BIT_FIRST   = 4'h1;  // first data bit
    localparam logic [3:0] ACI_SEL_DONE    = 4'h4;  // type and channel bits are in
    localparam logic [3:0] ACI_BYTE_DONE   = 4'h8;  // last data bit / direction bit
    localparam logic [3:0] ACI_ACK_PULSE   = 4'h9;  // acknowledge pulse

    // command byte field positions
    localparam int         ACI_CMD_TYPE    = 7;     // 1 single-ended, 0 differential
    localparam int         ACI_CMD_SEL_HI  = 6;     // channel select, top bit
    localparam int         ACI_CMD_SEL_LO  = 4;     // channel select, bottom bit
    localparam int         ACI_CMD_PM_HI   = 3;     // power mode, reference enable bit
    localparam int         ACI_CMD_PM_LO   = 2;     // power mode, converter bit

    // values after reset
    localparam logic [1:0] ACI_PM_RST      = 2'h0;  // power down, reference off
    localparam logic [3:0] ACI_SEL_RST     = 4'h0;  // differential, pair 0/1
    localparam logic [7:0] ACI_RESULT_RST  = 8'h00;
    localparam logic [1:0] ACI_STRAP_RST   = 2'h0;

    // width of the crossing bundle: cmd, addr, stop, hs-read toggles/levels + pm + select
    localparam int         ACI_XING_W      = 10;

    // link-side byte framing
    typedef enum {
        ACI_LK_IDLE,    // not addressed, waiting for a start
        ACI_LK_ADDR,    // shifting in the address byte
        ACI_LK_WR,      // addressed for write, command bytes follow
        ACI_LK_RD,      // addressed for read, result bytes go out
        ACI_LK_MCODE    // high-speed master code seen, no ack
    } aci_link_state_type;

endpackage : aci_pkg

// ### aci_sync.sv
// Purpose: two-flop level synchroniser into the system clock domain
// Assumes: inputs are levels or toggles that stay put for several clk cycles
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ns
module aci_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    import aci_pkg::*;

    logic [WIDTH-1:0] meta_r;   // first stage, metastability catcher

    // two stages, no logic between them
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : aci_sync

// ### aci_sar.sv
// Purpose: successive approximation sequencer, one comparator decision per cycle
// Assumes: the comparator output is settled against the trial word each clk cycle
// Notes:   a start while busy is ignored; result only changes at the end of a run
`timescale 1ns/1ns
module aci_sar #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             start,
    input  wire logic             cmp_high,
    output logic                  busy_r,
    output logic                  done_r,
    output logic      [WIDTH-1:0] trial_r,
    output logic      [WIDTH-1:0] result_r
);
    import aci_pkg::*;

    logic [$clog2(WIDTH)-1:0] idx_r;      // bit under test
    logic [WIDTH-1:0]         trial_nxt;  // trial word after this decision

    // keep the decided bit, try the next lower one as 1
    always_comb begin
        trial_nxt        = trial_r;
        trial_nxt[idx_r] = cmp_high;
        if (idx_r != '0) begin
            trial_nxt[idx_r - 1'b1] = 1'b1;
        end
    end

    // R23 msb-first search
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_r   <= 1'b0;
            done_r   <= 1'b0;
            idx_r    <= '0;
            trial_r  <= '0;
            result_r <= ACI_RESULT_RST;
        end else begin
            done_r <= 1'b0;
            if (start && !busy_r) begin
                // R23 clear all but top
                trial_r <= {1'b1, {(WIDTH-1){1'b0}}};
                idx_r   <= ($clog2(WIDTH))'(WIDTH - 1);
                busy_r  <= 1'b1;
            end else if (busy_r) begin
                trial_r <= trial_nxt;
                if (idx_r == '0) begin
                    // last decision: publish the word in one step
                    busy_r   <= 1'b0;
                    done_r   <= 1'b1;
                    result_r <= trial_nxt;
                end else begin
                    idx_r <= idx_r - 1'b1;
                end
            end
        end
    end

endmodule : aci_sar

// ### aci_top.sv
// Purpose: two-wire slave front end of an eight-input approximation converter
// Assumes: scl_clk is the bus clock pin used as clock; sda_i changes only while it is low
// Notes:   link logic runs on scl_clk edges, control and the converter run on clk
//
// Operation
// R1 - address is 10010 plus two strap bits
// R2 - latch straps at first eighth-pulse rising edge
// R3 - straps 00..11 give 0x48..0x4B, high first
// R4 - start is sda falling while scl high
// R5 - shift eight bits msb first, last is direction
// R6 - ack matched address on ninth pulse, else idle
// R7 - sda only changes while scl low
// R8 - nine pulses per byte, unlimited bytes
// R9 - master ends write with stop
// R10 - master nacks then stops to end read
// R11 - command bit 7 picks single or differential
// R12 - bits 6..4 channel, bits 1..0 ignored
// R13 - bits 3..2 select power and reference mode
// R14 - differential pair by low bits, top orders
// R15 - single-ended positive is two low plus top
// R16 - start conversion after select bits, then ack
// R17 - read returns result byte msb first
// R18 - converter and clock off when idle
// R19 - master code gets nack, enters high speed
// R20 - high-speed read stretches scl until done
// R21 - repeated start keeps, stop leaves high speed
// R22 - reference off at power-up, then bit 3
// R23 - approximation msb first, one bit per cycle
// R24 - no conversion, mode zero before first command
// R25 - master waits for reference settling
`timescale 1ns/1ns
module aci_top #(
    parameter int RES_W = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             scl_clk,
    output logic                  scl_o,
    output logic                  scl_oe,
    input  wire logic             sda_i,
    output logic                  sda_o,
    output logic                  sda_oe,
    input  wire logic             strap_high,
    input  wire logic             strap_low,
    input  wire logic             cmp_high,
    output logic      [RES_W-1:0] approximation_register,
    output logic      [RES_W-1:0] conversion_result,
    output logic      [2:0]       pos_input_sel,
    output logic      [2:0]       neg_input_sel,
    output logic                  neg_is_common,
    output logic                  reference_enable,
    output logic                  converter_power,
    output logic                  int_clk_enable,
    output logic                  conv_busy
);
    import aci_pkg::*;

    // ---------------- bus edge detectors (sda used as event clock) ----------------
    logic               start_tgl_r;    // flips on every start or repeated start
    logic               stop_tgl_r;     // flips on every stop

    // ---------------- link domain, rising scl edges ----------------
    aci_link_state_type phase_r;        // what the current byte means
    logic [3:0]         bit_cnt_r;      // pulse number inside the byte, 1..9
    logic [7:0]         shreg_r;        // incoming bits, msb first
    logic               start_seen_r;   // copy of start toggle already handled
    logic               stop_seen_r;    // copy of stop toggle already handled
    logic               ack_due_r;      // drive ack in the coming low phase
    logic               cmd_old_r;      // command toggle one clk older, kept on clk rather than on scl edges
    logic [1:0]         strap_meta_r;   // strap sync stage 1
    logic [1:0]         strap_s_r;      // strap sync stage 2
    logic [1:0]         strap_r;        // straps latched at first transaction
    logic               strap_got_r;    // straps have been latched
    logic [3:0]         sel_r;          // type bit and channel select
    logic [1:0]         power_mode_r;   // power mode field of latest command
    logic               cmd_tgl_r;      // flips when a conversion is requested
    logic               addr_tgl_r;     // flips when we are addressed
    logic               hs_r;           // high-speed mode active
    logic               rd_hs_r;        // high-speed read waiting for data

    // ---------------- link domain, falling scl edges ----------------
    logic [7:0]         tx_r;           // remaining result bits to send

    // ---------------- decode of the current rising edge ----------------
    logic               new_frame;      // first bit after a start
    logic [3:0]         cnt_nxt;        // pulse number of this edge
    logic [7:0]         byte_w;         // byte with this edge's bit included
    logic [1:0]         strap_eff;      // straps in force for this compare
    logic               addr_hit;       // address byte names this device
    logic               mcode_hit;      // address byte is a high-speed code

    // ---------------- system clock domain ----------------
    logic [ACI_XING_W-1:0] xing_w;      // bundle into the synchroniser
    logic [ACI_XING_W-1:0] xsync_w;     // synchronised bundle
    logic               cmd_prev_r;     // last seen command toggle
    logic               addr_prev_r;    // last seen address toggle
    logic               stop_prev_r;    // last seen stop toggle
    logic               adr_flag_r;     // addressed since the last stop
    logic               conv_start;     // one-cycle conversion request
    logic               sar_busy;       // conversion running
    logic [RES_W-1:0]   sar_trial;      // word under test
    logic [RES_W-1:0]   sar_result;     // last finished word

    // R4 start detect
    always_ff @(negedge sda_i or posedge rst) begin
        if (rst) begin
            start_tgl_r <= 1'b0;
        end else if (scl_clk) begin
            start_tgl_r <= ~start_tgl_r;
        end
    end

    // R7 stop detect, a rise while high flips the stop toggle; byte framing holds until the next start
    always_ff @(posedge sda_i or posedge rst) begin
        if (rst) begin
            stop_tgl_r <= 1'b0;
        end else if (scl_clk) begin
            stop_tgl_r <= ~stop_tgl_r;
        end
    end

    assign new_frame = (start_tgl_r != start_seen_r);
    assign cnt_nxt   = (bit_cnt_r == ACI_ACK_PULSE) ? ACI_BIT_FIRST : bit_cnt_r + 4'h1;
    assign byte_w    = {shreg_r[6:0], sda_i};
    // straps are read live until they are latched, so the first compare uses them too
    assign strap_eff = strap_got_r ? strap_r : strap_s_r;
    // R1 R3 address compare, high strap more significant
    assign addr_hit  = (byte_w[7:1] == {ACI_ADDR_UPPER, strap_eff});
    assign mcode_hit = (byte_w[7:3] == ACI_MCODE_UPPER);

    // R5 R8 byte framing, a start always wins over the running byte
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            phase_r      <= ACI_LK_IDLE;
            bit_cnt_r    <= ACI_BIT_FIRST;
            shreg_r      <= 8'h00;
            start_seen_r <= 1'b0;
            ack_due_r    <= 1'b0;
        end else if (new_frame) begin
            // first address bit arrives on this edge
            start_seen_r <= start_tgl_r;
            phase_r      <= ACI_LK_ADDR;
            bit_cnt_r    <= ACI_BIT_FIRST;
            shreg_r      <= {7'h00, sda_i};
            ack_due_r    <= 1'b0;
        end else if (phase_r != ACI_LK_IDLE) begin
            bit_cnt_r <= cnt_nxt;
            shreg_r   <= byte_w;
            // R6 ack address hit; R16 ack every command byte
            ack_due_r <= (cnt_nxt == ACI_BYTE_DONE) &&
                         (((phase_r == ACI_LK_ADDR) && addr_hit) || (phase_r == ACI_LK_WR));
            case (phase_r)
                ACI_LK_ADDR: begin
                    if (cnt_nxt == ACI_BYTE_DONE) begin
                        // R19 master code first, it never matches our address
                        if (mcode_hit) begin
                            phase_r <= ACI_LK_MCODE;
                        end else if (addr_hit) begin
                            // R5 direction bit, 1 is a read
                            phase_r <= sda_i ? ACI_LK_RD : ACI_LK_WR;
                        end else begin
                            // R6 other address, stay off the bus
                            phase_r <= ACI_LK_IDLE;
                        end
                    end
                end
                ACI_LK_MCODE: begin
                    // no ack here; wait idle for the repeated start
                    if (cnt_nxt == ACI_ACK_PULSE) begin
                        phase_r <= ACI_LK_IDLE;
                    end
                end
                ACI_LK_RD: begin
                    // R10 master nack ends our driving
                    if ((cnt_nxt == ACI_ACK_PULSE) && sda_i) begin
                        phase_r <= ACI_LK_IDLE;
                    end
                end
                ACI_LK_WR: begin
                    // write bytes keep coming until a stop or start
                    phase_r <= ACI_LK_WR;
                end
                default: begin
                    phase_r <= ACI_LK_IDLE;
                end
            endcase
        end
    end

    // strap pins are asynchronous levels: two stages on the link clock
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            strap_meta_r <= ACI_STRAP_RST;
            strap_s_r    <= ACI_STRAP_RST;
        end else begin
            strap_meta_r <= {strap_high, strap_low};
            strap_s_r    <= strap_meta_r;
        end
    end

    // R2 latch straps once, at the eighth pulse of the first address byte
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            strap_r     <= ACI_STRAP_RST;
            strap_got_r <= 1'b0;
        end else if (!new_frame && (phase_r == ACI_LK_ADDR) &&
                     (cnt_nxt == ACI_BYTE_DONE) && !strap_got_r) begin
            strap_r     <= strap_s_r;
            strap_got_r <= 1'b1;
        end
    end

    // R24 fields stay zero until the first command byte
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            sel_r        <= ACI_SEL_RST;
            power_mode_r <= ACI_PM_RST;
            cmd_tgl_r    <= 1'b0;
        end else if (!new_frame && (phase_r == ACI_LK_WR)) begin
            if (cnt_nxt == ACI_SEL_DONE) begin
                // R11 R12 R16 type and channel in, request conversion now
                sel_r     <= byte_w[3:0];
                cmd_tgl_r <= ~cmd_tgl_r;
            end else if (cnt_nxt == ACI_BYTE_DONE) begin
                // R13 R12 power mode kept, low two bits dropped
                power_mode_r <= byte_w[ACI_CMD_PM_HI:ACI_CMD_PM_LO];
            end
        end
    end

    // high-speed mode, address events and stop bookkeeping
    always_ff @(posedge scl_clk or posedge rst) begin
        if (rst) begin
            hs_r        <= 1'b0;
            stop_seen_r <= 1'b0;
            addr_tgl_r  <= 1'b0;
            rd_hs_r     <= 1'b0;
        end else if (new_frame) begin
            // R21 only a stop since the last frame leaves high speed
            if (stop_tgl_r != stop_seen_r) begin
                hs_r <= 1'b0;
            end
            stop_seen_r <= stop_tgl_r;
            rd_hs_r     <= 1'b0;
        end else if ((phase_r == ACI_LK_ADDR) && (cnt_nxt == ACI_BYTE_DONE)) begin
            if (mcode_hit) begin
                // R19 enter high speed
                hs_r <= 1'b1;
            end else if (addr_hit) begin
                addr_tgl_r <= ~addr_tgl_r;
                // R20 a high-speed read asks for stretching
                rd_hs_r    <= hs_r && sda_i;
            end
        end
    end

    // R6 R17 R7 sda changes only on the falling scl edge
    always_ff @(negedge scl_clk or posedge rst) begin
        if (rst) begin
            sda_oe <= 1'b0;
            tx_r   <= 8'h00;
        end else if (ack_due_r && (bit_cnt_r == ACI_BYTE_DONE)) begin
            // pull low for the ninth pulse
            sda_oe <= 1'b1;
        end else if ((phase_r == ACI_LK_RD) && (bit_cnt_r == ACI_ACK_PULSE)) begin
            // result is quiet here: it moves only at the end of a conversion
            sda_oe <= ~sar_result[RES_W-1];
            tx_r   <= {sar_result[RES_W-2:0], 1'b0};
        end else if ((phase_r == ACI_LK_RD) && (bit_cnt_r < ACI_BYTE_DONE)) begin
            sda_oe <= ~tx_r[7];
            tx_r   <= {tx_r[6:0], 1'b0};
        end else begin
            sda_oe <= 1'b0;
        end
    end

    // ---------------- crossing into the system clock ----------------
    assign xing_w = {cmd_tgl_r, addr_tgl_r, stop_tgl_r, rd_hs_r, power_mode_r, sel_r};

    aci_sync #(
        .WIDTH (ACI_XING_W)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   (xing_w),
        .q   (xsync_w)
    );

    // R16 R24 only a command toggle can start a conversion; one clk late so that
    // the select bits, which flip on the same scl edge, have settled past the sync
    assign conv_start = cmd_prev_r ^ cmd_old_r;

    // toggle history for edge recovery
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_prev_r  <= 1'b0;
            cmd_old_r   <= 1'b0;
            addr_prev_r <= 1'b0;
            stop_prev_r <= 1'b0;
        end else begin
            cmd_prev_r  <= xsync_w[9];
            cmd_old_r   <= cmd_prev_r;
            addr_prev_r <= xsync_w[8];
            stop_prev_r <= xsync_w[7];
        end
    end

    // addressed flag: a new address sets it, a stop clears it, set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            adr_flag_r <= 1'b0;
        end else if (xsync_w[8] ^ addr_prev_r) begin
            adr_flag_r <= 1'b1;
        end else if (xsync_w[7] ^ stop_prev_r) begin
            adr_flag_r <= 1'b0;
        end
    end

    // R14 R15 input multiplexer setting, held for the whole conversion
    always_ff @(posedge clk) begin
        if (rst) begin
            pos_input_sel <= 3'h0;
            neg_input_sel <= 3'h1;
            neg_is_common <= 1'b0;
        end else if (conv_start && !sar_busy) begin
            // positive side is the same number in both modes
            pos_input_sel <= {xsync_w[1:0], xsync_w[2]};
            neg_input_sel <= {xsync_w[1:0], ~xsync_w[2]};
            // R11 single-ended returns to the common input
            neg_is_common <= xsync_w[3];
        end
    end

    // R22 R13 reference follows the latest upper power bit, off at reset
    always_ff @(posedge clk) begin
        if (rst) begin
            reference_enable <= 1'b0;
        end else begin
            reference_enable <= xsync_w[5];
        end
    end

    // R18 R13 converter and its clock only while busy, addressed or kept on
    always_ff @(posedge clk) begin
        if (rst) begin
            converter_power <= 1'b0;
            int_clk_enable  <= 1'b0;
        end else begin
            converter_power <= sar_busy | conv_start | adr_flag_r | xsync_w[4];
            int_clk_enable  <= sar_busy | conv_start | adr_flag_r | xsync_w[4];
        end
    end

    // R20 hold scl low while a high-speed read waits for the converter
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_oe <= 1'b0;
            scl_o  <= 1'b0;
            sda_o  <= 1'b0;
        end else begin
            // lands two to three clk cycles after the read address: a limitation
            scl_oe <= xsync_w[6] & (sar_busy | conv_start);
            scl_o  <= 1'b0;
            sda_o  <= 1'b0;
        end
    end

    // R23 approximation engine
    aci_sar #(
        .WIDTH (RES_W)
    ) u_sar (
        .clk      (clk),
        .rst      (rst),
        .start    (conv_start),
        .cmp_high (cmp_high),
        .busy_r   (sar_busy),
        .done_r   (),
        .trial_r  (sar_trial),
        .result_r (sar_result)
    );

    // R17 result and trial word are flop outputs of the engine
    assign approximation_register = sar_trial;
    assign conversion_result      = sar_result;
    assign conv_busy              = sar_busy;

endmodule : aci_top

// ### aci_top_asserts.sv
// Purpose: port checks of the converter front end
// Assumes: one clk domain, rst synchronous
// Notes:   bound to aci_top below
`timescale 1ns/1ns
module aci_top_asserts #(
    parameter int RES_W = 8
) (
    input logic             clk,
    input logic             rst,
    input logic             scl_o,
    input logic             sda_o,
    input logic             scl_oe,
    input logic [RES_W-1:0] approximation_register,
    input logic [RES_W-1:0] conversion_result,
    input logic [2:0]       pos_input_sel,
    input logic [2:0]       neg_input_sel,
    input logic             neg_is_common,
    input logic             reference_enable,
    input logic             converter_power,
    input logic             int_clk_enable,
    input logic             conv_busy
);
    // all checks sample on clk and sleep during reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    chk_conv_length: assert property (
        $rose(conv_busy) |-> conv_busy[*8] ##1 !conv_busy)
        else $error("conversion length wrong");
    chk_trial_start: assert property (
        $rose(conv_busy) |-> ##[0:1] approximation_register == 8'h80)
        else $error("trial word not cleared");
    chk_result_hold: assert property (
        $changed(conversion_result) |-> !conv_busy)
        else $error("result moved mid conversion");
    chk_diff_pair: assert property (
        !neg_is_common |-> neg_input_sel == (pos_input_sel ^ 3'h1))
        else $error("differential pair broken");
    chk_ref_boot: assert property ($fell(rst) |-> !reference_enable)
        else $error("reference on after reset");
    chk_busy_power: assert property (
        conv_busy && $past(conv_busy) |-> converter_power && int_clk_enable)
        else $error("core off while converting");
    chk_pins_open: assert property (!sda_o && !scl_o)
        else $error("pin driven high");
    chk_stretch_end: assert property ($fell(conv_busy) |-> ##[0:2] !scl_oe)
        else $error("clock held after conversion");
    // main scenarios seen at least once
    cover property ($rose(conv_busy));
    cover property (neg_is_common && pos_input_sel == 3'h7);
    cover property ($rose(reference_enable));
endmodule : aci_top_asserts

bind aci_top aci_top_asserts #(.RES_W(RES_W)) aci_top_asserts_i (.clk, .rst, .scl_o, .sda_o,
    .scl_oe, .approximation_register, .conversion_result, .pos_input_sel, .neg_input_sel,
    .neg_is_common, .reference_enable, .converter_power, .int_clk_enable, .conv_busy);

// ### aci_master.sv
// Purpose: behavioural two-wire bus master
// Assumes: wired-and pull-ups resolved by the bench
// Notes:   48 ns clock only inside frames, high between them
`timescale 1ns/1ns
module aci_master (
    input  logic scl,   // resolved clock wire
    input  logic sda,   // resolved data wire
    output logic scl_m, // low pulls clock down
    output logic sda_m  // low pulls data down
);
    // bus idles high
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end
    task automatic start;
        #12 sda_m = 1'b1;
        #12 scl_m = 1'b1;
        #24 sda_m = 1'b0;
        #24 scl_m = 1'b0;
    endtask : start
    // nine pulses, data moves only while clock low
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #12 sda_m = tx[i];
            #12 scl_m = 1'b1;
            wait (scl);       // a stretched clock is honoured
            rx[i] = sda;
            #24 scl_m = 1'b0;
        end
    endtask : xfer
    task automatic stop;
        #12 sda_m = 1'b0;
        #12 scl_m = 1'b1;
        #24 sda_m = 1'b1;
        #24;
    endtask : stop
endmodule : aci_master

// ### aci_top_tb_top.sv
// Purpose: self-checking bench of the converter front end
// Assumes: comparator follows a random input level
// Notes:   so each result must equal that level
`timescale 1ns/1ns
module aci_top_tb_top;
    logic       clk, rst, scl_o, scl_oe, sda_o, sda_oe, scl_m, sda_m, busy_q;
    logic       strap_high, strap_low, neg_is_common, reference_enable;
    logic       converter_power, int_clk_enable, conv_busy;
    logic [7:0] approximation_register, conversion_result, vin, v, cmd;
    logic [2:0] pos_input_sel, neg_input_sel, p;
    logic [8:0] rx;
    logic [14:0] q_exp[$]; // {result, pos, common, neg}
    int         errors, n_checks, seed;
    wire        scl = scl_m & ~scl_oe; // open-drain wires with pull-ups
    wire        sda = sda_m & ~sda_oe;
    wire        cmp_high = vin >= approximation_register;
    aci_top aci_top_i (.clk, .rst, .scl_clk(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe,
        .strap_high, .strap_low, .cmp_high, .approximation_register, .conversion_result,
        .pos_input_sel, .neg_input_sel, .neg_is_common, .reference_enable, .converter_power,
        .int_clk_enable, .conv_busy);
    aci_master aci_master_i (.scl, .sda, .scl_m, .sda_m);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    // address phase with expected answer
    task automatic addr(input logic [7:0] a, input logic ack);
        aci_master_i.start();
        aci_master_i.xfer({a, 1'b1}, rx);
        chk(rx[0] === !ack, "address answer");
    endtask : addr
    // watcher: oldest note against each finished conversion
    always @(negedge clk) begin
        if (busy_q === 1'b1 && conv_busy === 1'b0)
            chk(q_exp.size() > 0 && {conversion_result, pos_input_sel, neg_is_common} ===
                q_exp[0][14:3] && (q_exp[0][3] || neg_input_sel === q_exp[0][2:0]), "conv");
        if (busy_q === 1'b1 && conv_busy === 1'b0 && q_exp.size() > 0)
            void'(q_exp.pop_front());
        busy_q = conv_busy;
    end
    initial begin
        {rst, vin, strap_high, strap_low, busy_q, errors, n_checks} = {1'b1, 75'h0};
        seed = 32'h9565ad69;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk({reference_enable, neg_input_sel, conv_busy} === 5'b00010, "reset");
        addr(8'h94, 1'b0);
        aci_master_i.stop();
        @(posedge clk);
        {strap_high, strap_low} <= 2'b10;
        addr(8'h08, 1'b0);
        aci_master_i.stop();
        for (int i = 0; i < 16; i++) begin
            repeat (4) @(posedge clk);
            v = 8'($random(seed));
            vin <= v;
            cmd = {i[3:0], 4'($random(seed))};
            p = {cmd[5:4], cmd[6]};
            q_exp.push_back({v, p, cmd[7], p ^ 3'h1});
            addr(8'h90, 1'b1);
            aci_master_i.xfer({cmd, 1'b1}, rx);
            chk(rx[0] === 1'b0, "command ack");
            aci_master_i.stop();
            for (int n = 0; n < 20 && conv_busy !== 1'b0; n++)
                @(posedge clk);
            chk(reference_enable === cmd[3], "reference");
            addr(8'h91, 1'b1);
            aci_master_i.xfer(9'h1ff, rx);
            chk(rx[8:1] === v, "read data");
            aci_master_i.stop();
        end
        results();
    end
    // watchdog
    initial begin
        #200000;
        errors++;
        results();
    end
endmodule : aci_top_tb_top
